// File: inc/ccic_map.vh
// Purpose: Register map, field layout and timing for the composite clock
//          input control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Byte address of a register is four times its index.
`ifndef CCIC_MAP_VH
`define CCIC_MAP_VH

`define CCIC_AW 12

`define CCIC_IDX_CTRL0 10'h07b
`define CCIC_IDX_CTRL1 10'h07c
`define CCIC_IDX_STAT  10'h07d
`define CCIC_IDX_IRQST 10'h080
`define CCIC_IDX_IRQMS 10'h081

`define CCIC_ADDR(i) {i, 2'h0}

`define CCIC_F_MODE_LO  0
`define CCIC_F_MODE_HI  1
`define CCIC_F_STYLE    2
`define CCIC_F_ALIGN_LO 3
`define CCIC_F_ALIGN_HI 4
`define CCIC_CTRL_W     5

`define CCIC_CTRL_RST   5'h00
`define CCIC_MASK_RST   6'h00
`define CCIC_STAT_W     6

`define CCIC_S_CC0      0
`define CCIC_S_8K0      1
`define CCIC_S_400_0    2
`define CCIC_S_CC1      3
`define CCIC_S_8K1      4
`define CCIC_S_400_1    5

`define CCIC_MODE_PLAIN 2'h0
`define CCIC_MODE_SPLIT 2'h1
`define CCIC_MODE_AUTO  2'h2

`define CCIC_ALIGN_8K   2'h1
`define CCIC_ALIGN_400  2'h2

`define CCIC_POS_FIRST  4'h1
`define CCIC_POS_LAST   4'h8

`define CCIC_GAP_OCTETS 5'h14

`define CCIC_CLK_NS     100
`define CCIC_LOSS_NS    32000
`define CCIC_LOSS_CYC   9'h140
`define CCIC_TMR_W      9

`endif

// File: hw/ccic_top.v
// Purpose: Composite clock input control for two reference/sync pairs.
// Assumes: Pair inputs are synchronous to clk; rst_n is synchronous.
// Notes:   Reference pin carries the positive rail, sync pin the negative.
//
// The implementer's own choice: register access over APB.
`include "ccic_map.vh"
`timescale 1ns/100ps
`default_nettype none

module ccic_pair
#(
  parameter [`CCIC_TMR_W-1:0] LOSS_CYC = `CCIC_LOSS_CYC,
  parameter [4:0]             GAP      = `CCIC_GAP_OCTETS
)
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       refIn,
  input  wire       syncIn,
  input  wire [1:0] mode,
  input  wire       style,
  input  wire [1:0] align,
  output wire       ccFound,
  output wire       sync8kFound,
  output wire       sync400Found,
  output wire       compositeActive,
  output wire       framePulse
);

  reg                   refD_q;
  reg                   syncD_q;
  reg                   lastNeg_q;
  reg                   havePol_q;
  reg [3:0]             pos_q;
  reg [4:0]             sinceGap_q;
  reg [`CCIC_TMR_W-1:0] timer_q;
  reg                   seenPos_q;
  reg                   seenNeg_q;
  reg                   found8k_q;
  reg                   found400_q;
  reg                   pulse_q;

  wire       enable;
  wire       markP;
  wire       markN;
  wire       mark;
  wire       neg;
  wire       bpv;
  wire [3:0] expPos;
  wire [3:0] rawNext;
  wire [3:0] posNext;
  wire       misaligned;
  wire       check;
  wire       gapValid;
  wire       timeout;

  // Reserved mode 11 is treated as plain so the decoder stays idle.
  assign enable = (mode == `CCIC_MODE_SPLIT) ||
                  (mode == `CCIC_MODE_AUTO);
  assign markP  = refIn & ~refD_q;
  assign markN  = syncIn & ~syncD_q;
  assign mark   = markP | markN;
  assign neg    = markN & ~markP;
  assign bpv    = mark & havePol_q & (neg == lastNeg_q);
  assign expPos = style ? `CCIC_POS_FIRST : `CCIC_POS_LAST;
  assign rawNext = (pos_q == `CCIC_POS_LAST) ? `CCIC_POS_FIRST :
                   pos_q + 4'h1;
  // A violation always realigns the octet counter to where it belongs.
  assign posNext    = bpv ? expPos : rawNext;
  assign misaligned = bpv & (rawNext != expPos);
  assign check      = mark & (posNext == expPos);
  assign gapValid   = check & ~bpv & found8k_q &
                      (sinceGap_q == GAP - 5'h01);
  assign timeout    = (timer_q == LOSS_CYC - 1'b1);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      refD_q  <= 1'b0;
      syncD_q <= 1'b0;
    end
    else
    begin
      refD_q  <= refIn;
      syncD_q <= syncIn;
    end
  end

  // Detection is live: a silent line or a plain mode clears every flag.
  // A mark on the last count keeps the pair alive instead of clearing it.
  always @(posedge clk)
  begin
    if (!rst_n || !enable || (timeout && !mark))
    begin
      lastNeg_q  <= 1'b0;
      havePol_q  <= 1'b0;
      pos_q      <= 4'h0;
      sinceGap_q <= 5'h00;
      seenPos_q  <= 1'b0;
      seenNeg_q  <= 1'b0;
      found8k_q  <= 1'b0;
      found400_q <= 1'b0;
    end
    else if (mark)
    begin
      lastNeg_q <= neg;
      havePol_q <= 1'b1;
      pos_q     <= posNext;
      if (neg)
        seenNeg_q <= 1'b1;
      else
        seenPos_q <= 1'b1;
      if (check && bpv)
      begin
        found8k_q <= ~misaligned;
        if (sinceGap_q == GAP - 5'h01)
          found400_q <= 1'b0;
        if (sinceGap_q < GAP)
          sinceGap_q <= sinceGap_q + 5'h01;
      end
      else if (check)
      begin
        sinceGap_q <= 5'h00;
        if (gapValid)
          found400_q <= 1'b1;
        else
        begin
          found8k_q  <= 1'b0;
          found400_q <= 1'b0;
        end
      end
      else if (bpv)
        found8k_q <= 1'b0;
    end
  end

  // The loss timer restarts on every mark, so only a silent line times out.
  always @(posedge clk)
  begin
    if (!rst_n || !enable || mark)
      timer_q <= {`CCIC_TMR_W{1'b0}};
    else if (!timeout)
      timer_q <= timer_q + 1'b1;
    else
      timer_q <= {`CCIC_TMR_W{1'b0}};
  end

  assign ccFound      = seenPos_q & seenNeg_q;
  assign sync8kFound  = found8k_q;
  assign sync400Found = found400_q;
  // Automatic mode only hands the pair to the decoder once it is seen.
  assign compositeActive = (mode == `CCIC_MODE_SPLIT) ||
                           ((mode == `CCIC_MODE_AUTO) && ccFound);

  // The pulse is registered, so it trails the checking mark by one cycle.
  // Codes 00 and 11 give no pulse, so a clear or fully set field stays quiet.
  always @(posedge clk)
  begin
    if (!rst_n)
      pulse_q <= 1'b0;
    else
    begin
      case (align)
        `CCIC_ALIGN_8K:
          pulse_q <= compositeActive & check & bpv & ~misaligned;
        `CCIC_ALIGN_400:
          pulse_q <= compositeActive & gapValid;
        default:
          pulse_q <= 1'b0;
      endcase
    end
  end

  assign framePulse = pulse_q;

endmodule

module ccic_top
(
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`CCIC_AW-1:0]    paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire                   referenceInputZero,
  input  wire                   syncInputZero,
  input  wire                   referenceInputOne,
  input  wire                   syncInputOne,
  output wire                   compositeActiveZero,
  output wire                   compositeActiveOne,
  output wire                   framePulseZero,
  output wire                   framePulseOne,
  output wire                   irq
);

  reg  [`CCIC_CTRL_W-1:0] ctrl0_q;
  reg  [`CCIC_CTRL_W-1:0] ctrl1_q;
  reg  [`CCIC_STAT_W-1:0] irqStat_q;
  reg  [`CCIC_STAT_W-1:0] irqMask_q;
  reg  [`CCIC_STAT_W-1:0] detPrev_q;
  reg  [31:0]             rdata_d;
  reg                     mapped;
  wire [`CCIC_STAT_W-1:0] detect;
  wire                    setup;
  wire                    access;
  wire                    wrEn;

  // Both pairs use one decoder design; only their register fields differ.
  ccic_pair u_pair0
  (
    .clk             (clk),
    .rst_n           (rst_n),
    .refIn           (referenceInputZero),
    .syncIn          (syncInputZero),
    .mode            (ctrl0_q[`CCIC_F_MODE_HI:`CCIC_F_MODE_LO]),
    .style           (ctrl0_q[`CCIC_F_STYLE]),
    .align           (ctrl0_q[`CCIC_F_ALIGN_HI:`CCIC_F_ALIGN_LO]),
    .ccFound         (detect[`CCIC_S_CC0]),
    .sync8kFound     (detect[`CCIC_S_8K0]),
    .sync400Found    (detect[`CCIC_S_400_0]),
    .compositeActive (compositeActiveZero),
    .framePulse      (framePulseZero)
  );

  ccic_pair u_pair1
  (
    .clk             (clk),
    .rst_n           (rst_n),
    .refIn           (referenceInputOne),
    .syncIn          (syncInputOne),
    .mode            (ctrl1_q[`CCIC_F_MODE_HI:`CCIC_F_MODE_LO]),
    .style           (ctrl1_q[`CCIC_F_STYLE]),
    .align           (ctrl1_q[`CCIC_F_ALIGN_HI:`CCIC_F_ALIGN_LO]),
    .ccFound         (detect[`CCIC_S_CC1]),
    .sync8kFound     (detect[`CCIC_S_8K1]),
    .sync400Found    (detect[`CCIC_S_400_1]),
    .compositeActive (compositeActiveOne),
    .framePulse      (framePulseOne)
  );

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  // Read data is latched in the setup cycle, so no wait state is needed.
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign wrEn    = access & pwrite & mapped;

  always @*
  begin
    mapped  = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr)
      `CCIC_ADDR(`CCIC_IDX_CTRL0):
        rdata_d[`CCIC_CTRL_W-1:0] = ctrl0_q;
      `CCIC_ADDR(`CCIC_IDX_CTRL1):
        rdata_d[`CCIC_CTRL_W-1:0] = ctrl1_q;
      `CCIC_ADDR(`CCIC_IDX_STAT):
        rdata_d[`CCIC_STAT_W-1:0] = detect;
      `CCIC_ADDR(`CCIC_IDX_IRQST):
        rdata_d[`CCIC_STAT_W-1:0] = irqStat_q;
      `CCIC_ADDR(`CCIC_IDX_IRQMS):
        rdata_d[`CCIC_STAT_W-1:0] = irqMask_q;
      default:
        mapped = 1'b0;
    endcase
  end

  // A read shows the live status as it stood in the setup cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= rdata_d;
  end

  // Control bits 31:5 and mask bits 31:6 are not stored and read back as zero.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl0_q   <= `CCIC_CTRL_RST;
      ctrl1_q   <= `CCIC_CTRL_RST;
      irqMask_q <= `CCIC_MASK_RST;
    end
    else if (wrEn)
    begin
      case (paddr)
        `CCIC_ADDR(`CCIC_IDX_CTRL0):
          ctrl0_q <= pwdata[`CCIC_CTRL_W-1:0];
        `CCIC_ADDR(`CCIC_IDX_CTRL1):
          ctrl1_q <= pwdata[`CCIC_CTRL_W-1:0];
        `CCIC_ADDR(`CCIC_IDX_IRQMS):
          irqMask_q <= pwdata[`CCIC_STAT_W-1:0];
        default:
          ctrl0_q <= ctrl0_q;
      endcase
    end
  end

  // Any change of a detect bit is an event; a new event beats the clear.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      detPrev_q <= {`CCIC_STAT_W{1'b0}};
      irqStat_q <= {`CCIC_STAT_W{1'b0}};
    end
    else
    begin
      detPrev_q <= detect;
      if (wrEn && (paddr == `CCIC_ADDR(`CCIC_IDX_IRQST)))
        irqStat_q <= (irqStat_q & ~pwdata[`CCIC_STAT_W-1:0]) |
                     (detect ^ detPrev_q);
      else
        irqStat_q <= irqStat_q | (detect ^ detPrev_q);
    end
  end

  // The interrupt is a level; software drops it by clearing status bits.
  assign irq = |(irqStat_q & irqMask_q);

endmodule

`default_nettype wire

// File: bench/ccic_top_asserts.sv
// Purpose: Port assertions for the composite clock input control top.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound from the testbench; sees top-level ports only.
`timescale 1ns/100ps
`default_nettype none
module ccic_top_asserts
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        compositeActiveZero,
  input wire logic        compositeActiveOne,
  input wire logic        framePulseZero
);
  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  wire map = paddr == 12'h1ec || paddr == 12'h1f0 || paddr == 12'h1f4
          || paddr == 12'h200 || paddr == 12'h204;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  no_wait_a: assert property (pready == acc)
    else $error("pready not in access phase");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  addr_decode_a: assert property (acc |-> pslverr == !map)
    else $error("pslverr disagrees with map");
  err_read_a: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  split_on_a: assert property (
    wr && paddr == 12'h1ec && pwdata[1:0] == 2'h1 |=> compositeActiveZero)
    else $error("split mode not active");
  plain_off_a: assert property (
    wr && paddr == 12'h1ec && pwdata[1:0] == 2'h0 |=> !compositeActiveZero)
    else $error("plain mode active");
  reserved_off_a: assert property (
    wr && paddr == 12'h1f0 && pwdata[1:0] == 2'h3 |=> !compositeActiveOne)
    else $error("reserved mode active");
  mask_clear_a: assert property (
    wr && paddr == 12'h204 && pwdata[5:0] == 6'h0 |=> !irq)
    else $error("irq with mask clear");
  pulse_single_a: assert property (framePulseZero |=> !framePulseZero)
    else $error("frame pulse too long");
endmodule
`default_nettype wire

// File: bench/ccic_cc_source.sv
// Purpose: Composite clock source for one reference/sync pair.
// Assumes: Marks are one-cycle pulses with an idle cycle between.
// Notes:   Lines rest low while stopped, so no mark is sent.
`timescale 1ns/100ps
`default_nettype none
module ccic_cc_source
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic firstBit,
  input  wire logic gap,
  output var  logic refOut,
  output var  logic syncOut
);
  logic       phase_q;
  logic [3:0] bit_q;
  logic [4:0] oct_q;
  logic       pol_q;
  wire viol = bit_q == (firstBit ? 4'h1 : 4'h8)
           && !(gap && oct_q == 5'h13);
  initial
  begin
    refOut = 1'b0;
    syncOut = 1'b0;
  end
  always @(posedge clk)
  begin
    refOut  <= 1'b0;
    syncOut <= 1'b0;
    phase_q <= ~phase_q;
    if (!rst_n || !run)
    begin
      phase_q <= 1'b0;
      bit_q   <= 4'h1;
      oct_q   <= 5'h0;
      pol_q   <= 1'b0;
    end
    else if (!phase_q)
    begin
      // A violation repeats the last polarity, so the decoder can align.
      refOut  <= viol ? pol_q : ~pol_q;
      syncOut <= viol ? ~pol_q : pol_q;
      pol_q   <= viol ? pol_q : ~pol_q;
      bit_q   <= (bit_q == 4'h8) ? 4'h1 : bit_q + 4'h1;
      if (bit_q == 4'h8)
        oct_q <= (oct_q == 5'h13) ? 5'h0 : oct_q + 5'h1;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the composite clock input control.
// Assumes: 10 MHz clock, APB master with no fixed wait count.
// Notes:   Loss timeout is fixed in the pair, so the run waits it out.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run0 = 1'b0, run1 = 1'b0, gap0 = 1'b0, gap1 = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, irq, err;
  logic referenceInputZero, syncInputZero, referenceInputOne, syncInputOne;
  logic compositeActiveZero, compositeActiveOne;
  logic framePulseZero, framePulseOne;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  ccic_top i_dut
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .referenceInputZero(referenceInputZero), .syncInputZero(syncInputZero),
    .referenceInputOne(referenceInputOne), .syncInputOne(syncInputOne),
    .compositeActiveZero(compositeActiveZero),
    .compositeActiveOne(compositeActiveOne),
    .framePulseZero(framePulseZero), .framePulseOne(framePulseOne)
  );
  ccic_cc_source i_src0
  (
    .clk(clk), .rst_n(rst_n), .run(run0), .firstBit(1'b0), .gap(gap0),
    .refOut(referenceInputZero), .syncOut(syncInputZero)
  );
  ccic_cc_source i_src1
  (
    .clk(clk), .rst_n(rst_n), .run(run1), .firstBit(1'b1), .gap(gap1),
    .refOut(referenceInputOne), .syncOut(syncInputOne)
  );
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask
  task automatic pulse(input logic sel, input int len, input int num,
                       input string n);
    int cnt;
    cnt = 0;
    repeat (len)
    begin
      @(posedge clk);
      if ((sel ? framePulseOne : framePulseZero) === 1'b1)
        cnt++;
    end
    chk(n, num, cnt);
  endtask
  task automatic t_regs;
    rd(12'h1ec, 32'h0, "ctrl0 reset");
    rd(12'h1f0, 32'h0, "ctrl1 reset");
    rd(12'h1f4, 32'h0, "status reset");
    rd(12'h200, 32'h0, "irq status reset");
    rd(12'h204, 32'h0, "irq mask reset");
    apb(1'b1, 12'h1f0, 32'hffffffff);
    rd(12'h1f0, 32'h1f, "ctrl1 fields");
    apb(1'b1, 12'h1f0, 32'h0);
    apb(1'b1, 12'h1f4, 32'h3f);
    rd(12'h1f4, 32'h0, "status write");
    rd(12'h008, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask
  task automatic t_modes;
    @(posedge clk) run0 <= 1'b1;
    repeat (200) @(posedge clk);
    rd(12'h1f4, 32'h0, "plain status");
    apb(1'b1, 12'h1ec, 32'h09);
    @(posedge clk);
    chk("active zero", 32'h1, {31'h0, compositeActiveZero});
    repeat (100) @(posedge clk);
    rd(12'h1f4, 32'h03, "split status");
    pulse(1'b0, 32, 2, "pulse zero");
    rd(12'h200, 32'h03, "irq events");
    apb(1'b1, 12'h204, 32'h01);
    @(posedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h200, 32'h03);
    rd(12'h200, 32'h0, "irq cleared");
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h204, 32'h0);
    @(posedge clk) gap0 <= 1'b1;
    repeat (1000) @(posedge clk);
    rd(12'h1f4, 32'h07, "gap status");
    apb(1'b1, 12'h1ec, 32'h11);
    @(posedge clk);
    pulse(1'b0, 320, 1, "pulse 400");
    apb(1'b1, 12'h1ec, 32'h01);
    @(posedge clk);
    pulse(1'b0, 32, 0, "pulse none");
  endtask
  task automatic t_pair1;
    apb(1'b1, 12'h1f0, 32'h0e);
    @(posedge clk) run1 <= 1'b1;
    chk("auto idle", 32'h0, {31'h0, compositeActiveOne});
    repeat (100) @(posedge clk);
    rd(12'h1f4, 32'h1f, "pair one status");
    chk("auto found", 32'h1, {31'h0, compositeActiveOne});
    pulse(1'b1, 32, 2, "pulse one");
    @(posedge clk) gap1 <= 1'b1;
    repeat (700) @(posedge clk);
    rd(12'h1f4, 32'h3f, "pair one gap");
    @(posedge clk) run0 <= 1'b0;
    repeat (290) @(posedge clk);
    rd(12'h1f4, 32'h3f, "before loss");
    repeat (40) @(posedge clk);
    rd(12'h1f4, 32'h38, "after loss");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      complete_run;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_modes;
    t_pair1;
    complete_run;
  end
endmodule
bind ccic_top ccic_top_asserts i_chk
(
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq),
  .compositeActiveZero(compositeActiveZero),
  .compositeActiveOne(compositeActiveOne),
  .framePulseZero(framePulseZero)
);
`default_nettype wire
